// file: pkg/malt_pkg.sv
// Constants and types shared by the learning table and its helpers.
// Assumes a 250 MHz core clock and a synchronous active-high reset.
package malt_pkg;
   // Table geometry
   localparam int TABLE_DEPTH = 1024;
   localparam int ADDR_W = 48;
   localparam int PORT_W = 3;
   localparam int LEN_W = 11;
   localparam int STAMP_W = 9;

   // Timing: one time-stamp tick per second, aging period in ticks
   localparam int CLK_PERIOD_NS = 4;
   localparam int SECOND_NS = 1000000000;
   localparam int TICK_CYCLES = (SECOND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int AGE_PERIOD_S = 300;
   localparam int AGE_TICKS = AGE_PERIOD_S;

   // Frame length limits in bytes
   localparam logic [LEN_W-1:0] LEN_MIN = 11'h040;
   localparam logic [LEN_W-1:0] LEN_MAX_LONG = 11'h600;
   localparam logic [LEN_W-1:0] LEN_MAX_TAGGED = 11'h5f2;
   localparam logic [LEN_W-1:0] LEN_MAX_UNTAGGED = 11'h5ee;

   // Reset values
   localparam logic [STAMP_W-1:0] STAMP_RESET = 9'h000;

   typedef enum logic [0:0] {
      MALT_IDLE = 1'b0,
      MALT_LOOK = 1'b1
   } malt_state_t;
endpackage

// file: design/malt_tick.sv
// Free-running divider giving a one-cycle pulse every CYCLES clocks.
// Assumes CYCLES of at least one.
module malt_tick #(
   parameter int CYCLES = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Tick out
   output logic tick_o
);
   localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] cnt_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= (cnt_r == LAST);
         cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
      end
   end
endmodule

// file: design/malt_table.sv
// Source address learning table with migration, refresh and aging.
// Assumes receive MACs present one finished frame at a time, with error status known.
// Operation
// R1: Fully associative table, 1K 48-bit entries.
// R2: Learn only absent source on good frames.
// R3: Learning writes address, ingress port, time stamp.
// R4: Table full: replace the last entry.
// R5: Migration: stored address, different port, good.
// R6: Migration overwrites port of existing entry.
// R7: Every matching frame refreshes the time stamp.
// R8: Delete entries unrefreshed for 300 seconds.
// R9: Aging scans the table continuously.
// R10: Aging enable comes from a strap.
// R11: Strap low disables, high enables aging.
// R12: Under 64 or over maximum is illegal.
// R13: Length strap selects 1518/1522 or 1536.
// R14: Decide at frame end; writes beat aging.
// R15: Reset empties the whole table.
module malt_table
   import malt_pkg::*;
#(
   parameter int DEPTH = malt_pkg::TABLE_DEPTH,
   parameter int TICK_CYCLES = malt_pkg::TICK_CYCLES,
   parameter int AGE_TICKS = malt_pkg::AGE_TICKS
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_I,
   // Configuration straps, caught during reset
   input wire logic AGING_CONFIG_STRAP_I,
   input wire logic FRAME_LENGTH_CONFIG_STRAP_I,
   // Finished frame from a receive MAC
   input wire logic FRAME_VALID_I,
   output logic READY_O,
   input wire logic [malt_pkg::ADDR_W-1:0] SOURCE_STATION_ADDRESS_I,
   input wire logic [malt_pkg::PORT_W-1:0] INGRESS_PORT_I,
   input wire logic FRAME_ERROR_I,
   input wire logic VLAN_TAGGED_I,
   input wire logic [malt_pkg::LEN_W-1:0] FRAME_LENGTH_I,
   // Table events and state
   output logic LEARN_O,
   output logic MIGRATE_O,
   output logic AGED_O,
   output logic [$clog2(DEPTH):0] ENTRY_COUNT_O
);
   import malt_pkg::*;

   localparam int IDX_W = $clog2(DEPTH);
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DEPTH - 1);
   localparam logic [STAMP_W-1:0] AGE_LIM = STAMP_W'(AGE_TICKS);

   malt_state_t state_r;
   logic aging_en_r;
   logic len_long_r;
   logic [ADDR_W-1:0] key_r;
   logic [PORT_W-1:0] port_in_r;
   logic good_r;
   logic [DEPTH-1:0] valid_r;
   logic [ADDR_W-1:0] addr_tab [DEPTH];
   logic [PORT_W-1:0] port_tab [DEPTH];
   logic [STAMP_W-1:0] stamp_tab [DEPTH];
   logic [STAMP_W-1:0] now_r;
   logic [IDX_W-1:0] scan_r;
   logic [IDX_W-1:0] last_idx_r;
   logic [DEPTH-1:0] hit_vec;
   logic hit;
   logic full;
   logic [IDX_W-1:0] hit_idx;
   logic [IDX_W-1:0] free_idx;
   logic [IDX_W-1:0] widx;
   logic take;
   logic len_ok;
   logic do_learn;
   logic do_migrate;
   logic do_refresh;
   logic tab_wr;
   logic expired;
   logic age_kill;
   logic tick;
   logic [LEN_W-1:0] len_max;

   malt_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .tick_o(tick)
   );

   // Straps are held while reset is asserted and frozen after release
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         aging_en_r <= AGING_CONFIG_STRAP_I; // R10 R11
         len_long_r <= FRAME_LENGTH_CONFIG_STRAP_I; // R13
      end
   end

   assign READY_O = (state_r == MALT_IDLE);
   assign take = FRAME_VALID_I && READY_O;
   assign len_max = len_long_r ? LEN_MAX_LONG : (VLAN_TAGGED_I ? LEN_MAX_TAGGED : LEN_MAX_UNTAGGED); // R13
   assign len_ok = (FRAME_LENGTH_I >= LEN_MIN) && (FRAME_LENGTH_I <= len_max); // R12

   // Frame capture; one lookup per two cycles
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         state_r <= MALT_IDLE;
         key_r <= '0;
         port_in_r <= '0;
         good_r <= 1'b0;
      end else begin
         case (state_r)
            MALT_IDLE: begin
               if (take) begin
                  state_r <= MALT_LOOK;
                  key_r <= SOURCE_STATION_ADDRESS_I;
                  port_in_r <= INGRESS_PORT_I;
                  good_r <= !FRAME_ERROR_I && len_ok; // R2 R5 R12 R14
               end
            end
            MALT_LOOK: state_r <= MALT_IDLE;
            default: state_r <= MALT_IDLE;
         endcase
      end
   end

   // Parallel compare against every entry
   for (genvar g = 0; g < DEPTH; g++) begin : g_cmp
      assign hit_vec[g] = valid_r[g] && (addr_tab[g] == key_r); // R1
   end

   always_comb begin
      hit_idx = '0;
      free_idx = '0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (hit_vec[i]) begin
            hit_idx = IDX_W'(i);
         end
         if (!valid_r[i]) begin
            free_idx = IDX_W'(i);
         end
      end
   end

   assign hit = |hit_vec;
   assign full = &valid_r;
   assign widx = hit ? hit_idx : (full ? IDX_LAST : free_idx); // R4 R6
   assign do_learn = (state_r == MALT_LOOK) && !hit && good_r; // R2
   assign do_migrate = (state_r == MALT_LOOK) && hit && good_r && (port_tab[hit_idx] != port_in_r); // R5
   assign do_refresh = (state_r == MALT_LOOK) && hit; // R7
   assign tab_wr = do_learn || do_refresh;

   // Aging check on the entry under the scan pointer
   assign expired = (STAMP_W'(now_r - stamp_tab[scan_r]) >= AGE_LIM); // R8
   assign age_kill = aging_en_r && valid_r[scan_r] && expired && !(tab_wr && (widx == scan_r)); // R9 R11 R14

   // Stamp clock; full sweep is far shorter than a tick, so stamps never alias
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         now_r <= STAMP_RESET;
         scan_r <= '0;
      end else begin
         if (tick) begin
            now_r <= now_r + 1'b1;
         end
         scan_r <= (scan_r == IDX_LAST) ? '0 : scan_r + 1'b1; // R9
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         valid_r <= '0; // R15
      end else begin
         if (age_kill) begin
            valid_r[scan_r] <= 1'b0; // R8
         end
         if (do_learn) begin
            valid_r[widx] <= 1'b1; // R4
         end
      end
   end

   // Entry contents need no reset; valid bits guard them
   always_ff @(posedge REF_CLK_I) begin
      if (do_learn) begin
         addr_tab[widx] <= key_r; // R3
      end
      if (do_learn || do_migrate) begin
         port_tab[widx] <= port_in_r; // R3 R6
      end
      if (tab_wr) begin
         stamp_tab[widx] <= now_r; // R3 R7
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         LEARN_O <= 1'b0;
         MIGRATE_O <= 1'b0;
         AGED_O <= 1'b0;
         last_idx_r <= '0;
      end else begin
         LEARN_O <= do_learn;
         MIGRATE_O <= do_migrate;
         AGED_O <= age_kill;
         if (state_r == MALT_LOOK) begin
            last_idx_r <= widx;
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         ENTRY_COUNT_O <= '0; // R15
      end else if (do_learn && !full && !age_kill) begin
         ENTRY_COUNT_O <= ENTRY_COUNT_O + 1'b1;
      end else if (age_kill && !(do_learn && !full)) begin
         ENTRY_COUNT_O <= ENTRY_COUNT_O - 1'b1;
      end
   end

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);

   sequence take_s;
      FRAME_VALID_I && READY_O;
   endsequence

   sequence bad_take_s;
      take_s ##0 (FRAME_ERROR_I || FRAME_LENGTH_I < LEN_MIN);
   endsequence

   single_match_a: assert property ($onehot0(hit_vec)) // R1
      else $error("Source address stored twice");
   bad_frame_a: assert property (bad_take_s |-> ##2 (!LEARN_O && !MIGRATE_O)) // R2
      else $error("Bad frame learned or migrated");
   learn_write_a: assert property (LEARN_O |-> valid_r[last_idx_r] && addr_tab[last_idx_r] == key_r
                                   && port_tab[last_idx_r] == port_in_r) // R3
      else $error("Learned entry content wrong");
   full_replace_a: assert property (do_learn && full |=> last_idx_r == IDX_LAST) // R4
      else $error("Full table did not replace last entry");
   migrate_port_a: assert property (do_migrate |=> MIGRATE_O && port_tab[last_idx_r] == $past(port_in_r)
                                   && ENTRY_COUNT_O <= $past(ENTRY_COUNT_O)) // R6
      else $error("Migration did not overwrite port");
   refresh_stamp_a: assert property (do_refresh |=> stamp_tab[last_idx_r] == $past(now_r)) // R7
      else $error("Time stamp not refreshed");
   age_remove_a: assert property (age_kill |=> AGED_O && !valid_r[$past(scan_r)]) // R8
      else $error("Expired entry not removed");
   age_off_a: assert property (!aging_en_r |-> !AGED_O) // R11
      else $error("Entry aged with aging disabled");
   strap_hold_a: assert property (!$past(RESET_I) |-> $stable(aging_en_r) && $stable(len_long_r)) // R10
      else $error("Strap value changed after reset");
   one_lookup_a: assert property (take_s |=> !READY_O ##1 READY_O) // R14
      else $error("Lookup timing wrong");
   write_wins_a: assert property (tab_wr && widx == scan_r |=> valid_r[$past(widx)]) // R14
      else $error("Aging beat a table write");
   reset_empty_a: assert property (disable iff (1'b0) $past(RESET_I) |-> valid_r == '0) // R15
      else $error("Table not empty after reset");
endmodule

// file: tb/malt_mac_model.sv
// Receive MAC model: hands the engine one finished frame at a time.
// Assumes the engine takes a frame on a rising edge that sees ready high.
module malt_mac_model
   import malt_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Finished frame to the engine
   input wire logic ready_i,
   output logic valid_o,
   output logic [malt_pkg::ADDR_W-1:0] addr_o,
   output logic [malt_pkg::PORT_W-1:0] port_o,
   output logic err_o,
   output logic tag_o,
   output logic [malt_pkg::LEN_W-1:0] len_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      valid_o = 1'b0;
      addr_o = '0;
      port_o = '0;
      err_o = 1'b0;
      tag_o = 1'b0;
      len_o = '0;
   end

   // Called just after a rising edge; returns just after the taking edge
   task automatic send(input logic [ADDR_W-1:0] a, input logic [PORT_W-1:0] p, input logic e, input logic t,
                       input logic [LEN_W-1:0] l, output logic ok);
      int n;
      ok = 1'b0;
      // Error status and length are final before the frame is offered
      valid_o = 1'b1;
      addr_o = a;
      port_o = p;
      err_o = e;
      tag_o = t;
      len_o = l;
      for (n = 0; n < 50 && !ok; n++) begin
         if (ready_i === 1'b1) ok = 1'b1;
         @(posedge clk_i);
         #1;
      end
      // Released lines show inverted data so stale values cannot match
      valid_o = 1'b0;
      addr_o = ~a;
      port_o = ~p;
      err_o = ~e;
      tag_o = ~t;
      len_o = ~l;
   endtask
endmodule

// file: tb/tb_mac_address_learning_table.sv
// Self-checking bench for the learning table with a small table and fast ticks.
// Assumes one receive MAC model drives the frame side.
module tb_mac_address_learning_table;
   import malt_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DEP = 4;
   logic clk, rst, age_s, len_s, ready, learn, mig, aged, valid, ferr, tag;
   logic [ADDR_W-1:0] addr;
   logic [PORT_W-1:0] port;
   logic [LEN_W-1:0] len;
   logic [2:0] cnt;
   int err_count, num_checks;

   malt_table #(.DEPTH(DEP), .TICK_CYCLES(64), .AGE_TICKS(3)) u_dut (
      .REF_CLK_I(clk), .RESET_I(rst), .AGING_CONFIG_STRAP_I(age_s), .FRAME_LENGTH_CONFIG_STRAP_I(len_s),
      .FRAME_VALID_I(valid), .READY_O(ready), .SOURCE_STATION_ADDRESS_I(addr), .INGRESS_PORT_I(port),
      .FRAME_ERROR_I(ferr), .VLAN_TAGGED_I(tag), .FRAME_LENGTH_I(len), .LEARN_O(learn), .MIGRATE_O(mig),
      .AGED_O(aged), .ENTRY_COUNT_O(cnt));
   malt_mac_model u_mac (.clk_i(clk), .ready_i(ready), .valid_o(valid), .addr_o(addr), .port_o(port),
      .err_o(ferr), .tag_o(tag), .len_o(len));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   task automatic do_reset(input logic a, input logic l);
      @(posedge clk);
      #1 rst = 1'b1;
      age_s = a;
      len_s = l;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      chk("count", 16'h0000, 16'(cnt));
   endtask

   // Answer pulse one edge after the take, one cycle wide
   task automatic frame(input logic [ADDR_W-1:0] a, input logic [PORT_W-1:0] p, input logic e, input logic t,
                        input logic [LEN_W-1:0] l, input logic el, input logic em);
      logic ok;
      u_mac.send(a, p, e, t, l, ok);
      chk("taken", 16'h0001, 16'(ok));
      if (!ok) begin
         wrap_up();
      end
      chk("ready", 16'h0000, 16'(ready));
      @(posedge clk);
      #1;
      chk("learn", 16'(el), 16'(learn));
      chk("migrate", 16'(em), 16'(mig));
      @(posedge clk);
      #1;
      chk("learn_end", 16'h0000, 16'(learn));
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Waits until the table is empty, watching for removal pulses
   task automatic wait_empty();
      int n;
      logic seen;
      seen = 1'b0;
      for (n = 0; n < 400 && cnt !== 3'h0; n++) begin
         @(posedge clk);
         #1;
         if (aged === 1'b1) seen = 1'b1;
      end
      chk("aged", 16'h0001, 16'(seen));
      if (cnt !== 3'h0) begin
         chk("count", 16'h0000, 16'(cnt));
         wrap_up();
      end
   endtask

   task automatic t_learn();
      do_reset(1'b1, 1'b1);
      frame(48'h0a0b0c0d0e01, 3'h1, 1'b0, 1'b0, 11'h040, 1'b1, 1'b0);
      frame(48'h0a0b0c0d0e01, 3'h1, 1'b0, 1'b0, 11'h100, 1'b0, 1'b0);
      chk("count", 16'h0001, 16'(cnt));
      $display("t_learn done");
   endtask

   task automatic t_qualify();
      frame(48'h00000000b0b0, 3'h2, 1'b1, 1'b0, 11'h100, 1'b0, 1'b0);
      frame(48'h00000000b0b0, 3'h2, 1'b0, 1'b0, 11'h03f, 1'b0, 1'b0);
      frame(48'h00000000b0b0, 3'h2, 1'b0, 1'b0, 11'h601, 1'b0, 1'b0);
      frame(48'h00000000b0b0, 3'h2, 1'b0, 1'b0, 11'h600, 1'b1, 1'b0);
      frame(48'h00000000b0b0, 3'h3, 1'b1, 1'b0, 11'h100, 1'b0, 1'b0);
      frame(48'h00000000b0b0, 3'h3, 1'b0, 1'b0, 11'h601, 1'b0, 1'b0);
      frame(48'h00000000b0b0, 3'h3, 1'b0, 1'b0, 11'h100, 1'b0, 1'b1);
      frame(48'h00000000b0b0, 3'h3, 1'b0, 1'b0, 11'h100, 1'b0, 1'b0);
      chk("count", 16'h0002, 16'(cnt));
      $display("t_qualify done");
   endtask

   task automatic t_full();
      do_reset(1'b1, 1'b1);
      for (int i = 0; i < DEP; i++) frame(48'(16 + i), 3'h0, 1'b0, 1'b0, 11'h080, 1'b1, 1'b0);
      chk("count", 16'(DEP), 16'(cnt));
      frame(48'h000000000099, 3'h0, 1'b0, 1'b0, 11'h080, 1'b1, 1'b0);
      chk("count", 16'(DEP), 16'(cnt));
      frame(48'(16 + DEP - 1), 3'h0, 1'b0, 1'b0, 11'h080, 1'b1, 1'b0);
      frame(48'h000000000010, 3'h1, 1'b0, 1'b0, 11'h080, 1'b0, 1'b1);
      $display("t_full done");
   endtask

   task automatic t_age();
      do_reset(1'b1, 1'b1);
      frame(48'h00000000c0c0, 3'h4, 1'b0, 1'b0, 11'h080, 1'b1, 1'b0);
      frame(48'h00000000d0d0, 3'h5, 1'b0, 1'b0, 11'h080, 1'b1, 1'b0);
      // Refresh before the third tick, so the unrefreshed entry ages out first
      idle(140);
      frame(48'h00000000d0d0, 3'h5, 1'b1, 1'b0, 11'h080, 1'b0, 1'b0);
      idle(100);
      chk("count", 16'h0001, 16'(cnt));
      wait_empty();
      $display("t_age done");
   endtask

   task automatic t_strap();
      do_reset(1'b0, 1'b0);
      frame(48'h00000000e0e0, 3'h6, 1'b0, 1'b1, 11'h5f2, 1'b1, 1'b0);
      frame(48'h00000000f0f0, 3'h6, 1'b0, 1'b0, 11'h5ef, 1'b0, 1'b0);
      frame(48'h00000000f0f0, 3'h6, 1'b0, 1'b0, 11'h5ee, 1'b1, 1'b0);
      frame(48'h00000000a0a0, 3'h7, 1'b0, 1'b1, 11'h5f3, 1'b0, 1'b0);
      idle(600);
      chk("count", 16'h0002, 16'(cnt));
      $display("t_strap done");
   endtask

   initial begin
      err_count = 0;
      num_checks = 0;
      rst = 1'b1;
      age_s = 1'b1;
      len_s = 1'b1;
      t_learn();
      t_qualify();
      t_full();
      t_age();
      t_strap();
      wrap_up();
   end
endmodule
